// ===== hw/ifr_device_end.sv
// Device end: command word, data window, direct range and fabric register space
//
// Summary of operation
// [R1] Host loads data window before write command
// [R2] Single write: one command with pending set
// [R3] Pending stays set until fabric write finishes
// [R4] Stepped writes: program command with step first
// [R5] Stepped write mode: data write starts write
// [R6] Stepped write done: clear pending, step offset
// [R7] Direct range write sets offset, lanes, write
// [R8] Only a fabric subset is reachable directly
// [R9] Single read: one command, read, no step
// [R10] Read: data valid in the same cycle that pending clears
// [R11] Stepped reads: program command with step first
// [R12] Stepped read: data read steps, relaunches read
// [R13] Host clears step bits before final read
// [R14] Host writes only while pending is clear
// [R15] Fabric write touches only selected byte lanes
// [R16] Both step bits set means no stepping
`timescale 1ns/1ns
`include "ifr_regs.svh"
module ifr_device_end (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  ifr_link_if.dev link,
  output logic access_pending_out,
  output ifr_pkg::ifr_offset_t target_offset_out,
  output logic access_fault_out
);
  import ifr_pkg::*;

  ifr_word_t fabric_data_window;
  ifr_offset_t target_offset;
  logic read_not_write;
  logic step_up;
  logic step_down;
  ifr_lane_t lane_select;
  logic access_pending;
  logic access_fault;
  ifr_dev_state_t state;
  logic [2:0] wait_cnt;
  ifr_word_t fabric_mem [`IFR_FABRIC_WORDS];

  function automatic ifr_word_t lane_merge(input ifr_word_t old_w, input ifr_word_t new_w,
                                           input ifr_lane_t lanes);
    ifr_word_t r;
    r = old_w;
    for (int i = 0; i < 4; i++) begin
      if (lanes[i]) begin
        r[8*i +: 8] = new_w[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Address decode of the system register bus
  wire hit_data = link.req_addr == `IFR_DATA_IDX;
  wire hit_cmd = link.req_addr == `IFR_CMD_IDX;
  // Only the mapped subset of the fabric is writable through the direct range
  wire hit_direct = (link.req_addr >= `IFR_DIRECT_BASE) &&
                    (link.req_addr <= `IFR_DIRECT_LAST); // [R8]
  wire ifr_offset_t direct_offset = `IFR_DIRECT_MAP_BASE +
                                    {8'h00, link.req_addr - `IFR_DIRECT_BASE}; // [R8]

  // Both step bits together cancel each other
  wire step_on = step_up ^ step_down; // [R16]
  wire ifr_offset_t stepped_offset = step_up ? target_offset + `IFR_OFFSET_STEP
                                             : target_offset - `IFR_OFFSET_STEP;

  // Writes that arrive while an access is pending are dropped
  wire idle_ok = !access_pending; // [R14]
  wire cmd_write = link.req_wr && hit_cmd && idle_ok;
  wire data_write = link.req_wr && hit_data && idle_ok; // [R1]
  wire launch_cmd = cmd_write && link.req_wdata[`IFR_CMD_PENDING]; // [R2] [R9]
  wire launch_step_wr = data_write && step_on && !read_not_write; // [R5] [R4]
  wire launch_direct = link.req_wr && hit_direct && idle_ok; // [R7]
  wire launch_step_rd = link.req_rd && hit_data && step_on && read_not_write &&
                        idle_ok; // [R12] [R11] [R13]
  wire launch = launch_cmd || launch_step_wr || launch_direct || launch_step_rd;

  wire fabric_fin = (state == DEV_BUSY) && (wait_cnt == 3'h0);
  wire in_range = target_offset < `IFR_FABRIC_WORDS;
  wire [5:0] mem_idx = target_offset[5:0];
  wire ifr_word_t mem_word = in_range ? fabric_mem[mem_idx] : '0;

  wire ifr_word_t cmd_word = {access_pending, read_not_write, step_down, step_up,
                              7'h00, access_fault, lane_select, target_offset};
  wire ifr_word_t read_mux = hit_data ? fabric_data_window :
                             hit_cmd ? cmd_word : '0;

  // Fabric access sequencer: fixed latency per access
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state <= DEV_IDLE;
      wait_cnt <= 3'h0;
    end else begin
      case (state)
        DEV_IDLE: begin
          if (launch) begin
            state <= DEV_BUSY;
            wait_cnt <= `IFR_FABRIC_CYCLES - 3'h1;
          end
        end
        DEV_BUSY: begin
          if (wait_cnt == 3'h0) begin
            state <= DEV_IDLE;
          end else begin
            wait_cnt <= wait_cnt - 3'h1;
          end
        end
        default: begin
          state <= DEV_IDLE;
        end
      endcase
    end
  end

  // Command word fields
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      target_offset <= `IFR_OFFSET_RESET;
      read_not_write <= 1'b0;
      step_up <= 1'b0;
      step_down <= 1'b0;
      lane_select <= `IFR_LANE_RESET;
      access_pending <= 1'b0;
    end else if (cmd_write) begin
      target_offset <= link.req_wdata[15:0];
      read_not_write <= link.req_wdata[`IFR_CMD_RNW];
      step_up <= link.req_wdata[`IFR_CMD_UP];
      step_down <= link.req_wdata[`IFR_CMD_DOWN];
      lane_select <= link.req_wdata[`IFR_CMD_LANE_HI:`IFR_CMD_LANE_LO];
      access_pending <= link.req_wdata[`IFR_CMD_PENDING]; // [R2] [R9]
    end else if (launch_direct) begin
      target_offset <= direct_offset; // [R7]
      lane_select <= `IFR_ALL_LANES; // [R7]
      read_not_write <= 1'b0; // [R7]
      access_pending <= 1'b1; // [R7]
    end else if (launch_step_wr) begin
      access_pending <= 1'b1; // [R5]
    end else if (launch_step_rd) begin
      target_offset <= stepped_offset; // [R12]
      access_pending <= 1'b1; // [R12]
    end else if (fabric_fin) begin
      // Pending holds through the whole access and drops with its last cycle
      access_pending <= 1'b0; // [R3] [R6] [R10]
      if (!read_not_write && step_on) begin
        target_offset <= stepped_offset; // [R6]
      end
    end
  end

  // Out-of-range offsets are flagged; a new command clears the flag
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      access_fault <= 1'b0;
    end else if (fabric_fin && !in_range) begin
      access_fault <= 1'b1;
    end else if (cmd_write) begin
      access_fault <= 1'b0;
    end
  end

  // Data window: host data in, fetched fabric data out
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      fabric_data_window <= `IFR_DATA_RESET;
    end else if (data_write || launch_direct) begin
      fabric_data_window <= link.req_wdata; // [R1] [R7]
    end else if (fabric_fin && read_not_write) begin
      fabric_data_window <= mem_word; // [R10]
    end
  end

  // Fabric register space
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      for (int i = 0; i < `IFR_FABRIC_WORDS; i++) begin
        fabric_mem[i] <= '0;
      end
    end else if (fabric_fin && !read_not_write && in_range) begin
      fabric_mem[mem_idx] <= lane_merge(fabric_mem[mem_idx], fabric_data_window,
                                        lane_select); // [R15] [R3]
    end
  end

  // Read answer one cycle after the request
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      link.rsp_valid <= 1'b0;
      link.rsp_data <= '0;
    end else begin
      link.rsp_valid <= link.req_rd;
      link.rsp_data <= link.req_rd ? read_mux : '0;
    end
  end

  // User-side status mirrors
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      access_pending_out <= 1'b0;
      target_offset_out <= `IFR_OFFSET_RESET;
      access_fault_out <= 1'b0;
    end else begin
      access_pending_out <= access_pending;
      target_offset_out <= target_offset;
      access_fault_out <= access_fault;
    end
  end
endmodule

// ===== hw/ifr_regs.svh
// Register indices, command word fields, reset values and timing counts
`ifndef IFR_REGS_SVH
`define IFR_REGS_SVH

`define IFR_DATA_IDX 8'h00
`define IFR_CMD_IDX 8'h01
`define IFR_DIRECT_BASE 8'h10
`define IFR_DIRECT_LAST 8'h1f
`define IFR_DIRECT_MAP_BASE 16'h0020

`define IFR_CMD_PENDING 31
`define IFR_CMD_RNW 30
`define IFR_CMD_DOWN 29
`define IFR_CMD_UP 28
`define IFR_CMD_FAULT 20
`define IFR_CMD_LANE_HI 19
`define IFR_CMD_LANE_LO 16

`define IFR_DATA_RESET 32'h0000_0000
`define IFR_OFFSET_RESET 16'h0000
`define IFR_LANE_RESET 4'h0
`define IFR_ALL_LANES 4'hf
`define IFR_OFFSET_STEP 16'h0001

`define IFR_FABRIC_WORDS 16'h0040
`define IFR_FABRIC_CYCLES 3'h4

`endif

// ===== hw/ifr_pkg.sv
// Shared types for the indirect fabric register bridge
package ifr_pkg;
  typedef logic [31:0] ifr_word_t;
  typedef logic [15:0] ifr_offset_t;
  typedef logic [7:0] ifr_index_t;
  typedef logic [3:0] ifr_lane_t;
  typedef enum logic [0:0] {DEV_IDLE, DEV_BUSY} ifr_dev_state_t;
  typedef enum logic [2:0] {
    HOST_IDLE, HOST_POLL, HOST_POLL_WAIT, HOST_WRITE, HOST_READ, HOST_READ_WAIT, HOST_ACK
  } ifr_host_state_t;
endpackage

// ===== hw/ifr_link_if.sv
// System register bus between the host end and the device end
`timescale 1ns/1ns
interface ifr_link_if;
  logic req_wr;
  logic req_rd;
  ifr_pkg::ifr_index_t req_addr;
  ifr_pkg::ifr_word_t req_wdata;
  logic rsp_valid;
  ifr_pkg::ifr_word_t rsp_data;
  modport dev (input req_wr, input req_rd, input req_addr, input req_wdata,
               output rsp_valid, output rsp_data);
  modport host (output req_wr, output req_rd, output req_addr, output req_wdata,
                input rsp_valid, input rsp_data);
endinterface

// ===== hw/ifr_host_end.sv
// Host end: Avalon-MM slave relaying software accesses onto the system register bus
`timescale 1ns/1ns
`include "ifr_regs.svh"
module ifr_host_end (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  ifr_link_if.host link,
  input wire ifr_pkg::ifr_index_t avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire ifr_pkg::ifr_word_t avs_writedata_in,
  output ifr_pkg::ifr_word_t avs_readdata_out,
  output logic avs_waitrequest_out
);
  import ifr_pkg::*;

  ifr_host_state_t state;

  // Writes that start or feed a fabric access wait for pending to clear
  wire guarded = (avs_address_in == `IFR_DATA_IDX) || (avs_address_in == `IFR_CMD_IDX) ||
                 ((avs_address_in >= `IFR_DIRECT_BASE) &&
                  (avs_address_in <= `IFR_DIRECT_LAST)); // [R14]
  wire still_pending = link.rsp_data[`IFR_CMD_PENDING]; // [R14]
  wire read_done = (state == HOST_READ_WAIT) && link.rsp_valid;

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      state <= HOST_IDLE;
    end else begin
      case (state)
        HOST_IDLE: begin
          if (avs_write_in) begin
            state <= guarded ? HOST_POLL : HOST_WRITE;
          end else if (avs_read_in) begin
            state <= HOST_READ;
          end
        end
        HOST_POLL: begin
          state <= HOST_POLL_WAIT;
        end
        HOST_POLL_WAIT: begin
          if (link.rsp_valid) begin
            state <= still_pending ? HOST_POLL : HOST_WRITE; // [R14]
          end
        end
        HOST_WRITE: begin
          state <= HOST_ACK;
        end
        HOST_READ: begin
          state <= HOST_READ_WAIT;
        end
        HOST_READ_WAIT: begin
          if (link.rsp_valid) begin
            state <= HOST_ACK;
          end
        end
        default: begin
          state <= HOST_IDLE;
        end
      endcase
    end
  end

  // Requests go out in software order, so data precedes its command [R1] [R4]
  // and command words pass with the fields software chose [R2] [R9] [R11] [R13]
  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      link.req_wr <= 1'b0;
      link.req_rd <= 1'b0;
      link.req_addr <= '0;
      link.req_wdata <= '0;
    end else begin
      link.req_wr <= state == HOST_WRITE;
      link.req_rd <= (state == HOST_POLL) || (state == HOST_READ);
      link.req_addr <= (state == HOST_POLL) ? `IFR_CMD_IDX : avs_address_in;
      link.req_wdata <= avs_writedata_in;
    end
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out <= '0;
    end else begin
      avs_waitrequest_out <= !((state == HOST_WRITE) || read_done);
      if (read_done) begin
        avs_readdata_out <= link.rsp_data;
      end
    end
  end
endmodule

// ===== tb/ifr_link_assertions.sv
// Checker for the link between the host end and the device end
`timescale 1ns/1ns
module ifr_link_assertions (
  input wire logic ref_clk_in,
  input wire logic reset_in,
  input wire logic req_wr,
  input wire logic req_rd,
  input wire ifr_pkg::ifr_index_t req_addr,
  input wire ifr_pkg::ifr_word_t req_wdata,
  input wire logic rsp_valid,
  input wire logic access_pending_out,
  input wire ifr_pkg::ifr_offset_t target_offset_out
);
  import ifr_pkg::*;
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  ifr_word_t mode;
  wire idle_wr = req_wr && !access_pending_out;
  wire cmd_go = idle_wr && req_addr == 8'h01 && req_wdata[31];
  wire dir_go = idle_wr && req_addr >= 8'h10 && req_addr <= 8'h1f;
  wire step = mode[28] ^ mode[29];
  wire dat_wr = idle_wr && req_addr == 8'h00;
  wire stw_go = dat_wr && step && !mode[30];
  wire str_go = req_rd && req_addr == 8'h00 && step && mode[30] && !access_pending_out;
  wire ifr_offset_t ofs_next = mode[29] ? target_offset_out - 16'h1 : target_offset_out + 16'h1;
  // Last accepted command fields decide what a data access does
  always_ff @(posedge ref_clk_in) begin
    if (reset_in)
      mode <= '0;
    else if (idle_wr && req_addr == 8'h01)
      mode <= req_wdata;
    else if (dir_go)
      mode[30] <= 1'b0;
  end
  sequence busy_run;
    ##1 access_pending_out [*4] ##1 !access_pending_out;
  endsequence
  AST_CMD_BUSY: assert property (cmd_go |=> busy_run) else $error("cmd busy");
  AST_DIR_BUSY: assert property (dir_go |=> busy_run) else $error("direct busy");
  AST_STW_BUSY: assert property (stw_go |=> busy_run) else $error("step wr busy");
  AST_STR_BUSY: assert property (str_go |=> busy_run) else $error("step rd busy");
  AST_DATA_IDLE: assert property (dat_wr && !stw_go |=> ##1 !access_pending_out [*4])
    else $error("data write started access");
  AST_STW_OFS: assert property (stw_go |=> ##5 target_offset_out == $past(ofs_next, 6))
    else $error("step wr offset");
  AST_STR_OFS: assert property (str_go |=> ##1 target_offset_out == $past(ofs_next, 2))
    else $error("step rd offset");
  AST_RSP_LAT: assert property (req_rd |=> rsp_valid) else $error("no response");
endmodule

// ===== tb/tb_indirect_fabric_reg_access.sv
// Self-checking bench driving software accesses through both bridge ends
`timescale 1ns/1ns
module tb_indirect_fabric_reg_access;
  import ifr_pkg::*;
  logic ref_clk_in = 0;
  logic reset_in = 1;
  logic avs_read_in = 0;
  logic avs_write_in = 0;
  ifr_index_t avs_address_in = '0;
  ifr_word_t avs_writedata_in = '0;
  ifr_word_t avs_readdata_out, q, d, seed = 32'h63aee462;
  ifr_word_t fm [64];
  logic [32:0] eq [$];
  logic avs_waitrequest_out, pend, fault;
  ifr_offset_t ofs, o;
  ifr_lane_t l;
  int err_total = 0, check_count = 0, cyc = 0, i, k;
  ifr_link_if link();
  ifr_host_end ifr_host_end_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .link(link),
    .avs_address_in(avs_address_in), .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
    .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
    .avs_waitrequest_out(avs_waitrequest_out));
  ifr_device_end ifr_device_end_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in), .link(link),
    .access_pending_out(pend), .target_offset_out(ofs), .access_fault_out(fault));
  ifr_link_assertions ifr_link_assertions_i (.ref_clk_in(ref_clk_in), .reset_in(reset_in),
    .req_wr(link.req_wr), .req_rd(link.req_rd), .req_addr(link.req_addr),
    .req_wdata(link.req_wdata), .rsp_valid(link.rsp_valid), .access_pending_out(pend),
    .target_offset_out(ofs));
  initial forever #10 ref_clk_in = ~ref_clk_in;
  function ifr_word_t rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task check(input ifr_word_t s, input ifr_word_t e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("BAD t=%0t seen %h expected %h", $time, s, e);
    end
  endtask
  task finish_test;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task av(input bit w, input ifr_index_t a, input ifr_word_t dv);
    @(posedge ref_clk_in);
    avs_write_in <= w;
    avs_read_in <= !w;
    avs_address_in <= a;
    avs_writedata_in <= dv;
    do @(posedge ref_clk_in); while (avs_waitrequest_out !== 1'b0);
    q = avs_readdata_out;
    avs_write_in <= 0;
    avs_read_in <= 0;
  endtask
  task wr(input ifr_index_t a, input ifr_word_t dv);
    av(1, a, dv);
  endtask
  task rd(input ifr_index_t a, input ifr_word_t e);
    eq.push_back({1'b1, e});
    av(0, a, 0);
  endtask
  task poll;
    do begin
      eq.push_back(33'h0);
      av(0, 8'h01, 0);
    end while (q[31] !== 1'b0);
  endtask
  task fetch(input ifr_offset_t t);
    wr(8'h01, {4'hc, 12'h000, t});
    poll;
    rd(8'h00, fm[t[5:0]]);
  endtask
  // Read results are compared against the oldest note
  always @(posedge ref_clk_in) begin
    if (avs_read_in === 1'b1 && avs_waitrequest_out === 1'b0 && eq.size() > 0) begin
      if (eq[0][32])
        check(avs_readdata_out, eq[0][31:0]);
      void'(eq.pop_front());
    end
  end
  always @(posedge ref_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      err_total++;
      finish_test;
    end
  end
  initial begin
    for (i = 0; i < 64; i++) fm[i] = '0;
    repeat (10) @(posedge ref_clk_in);
    reset_in <= 0;
    rd(8'h00, 0);
    rd(8'h01, 0);
    $display("reset test done");
    for (i = 0; i < 8; i++) begin
      d = rnd();
      o = {10'h000, d[5:0]};
      d = rnd();
      l = i ? d[27:24] : 4'hf;
      wr(8'h00, d);
      wr(8'h01, {4'h8, 8'h00, l, o});
      for (k = 0; k < 4; k++) if (l[k]) fm[o[5:0]][8*k +: 8] = d[8*k +: 8];
      fetch(o);
    end
    $display("single access test done");
    for (i = 0; i < 2; i++) begin
      o = i ? 16'd40 : 16'd30;
      wr(8'h01, {2'b00, i[0], !i[0], 8'h00, 4'hf, o});
      for (k = 0; k < 3; k++) begin
        d = rnd();
        fm[o[5:0]] = d;
        wr(8'h00, d);
        o = i ? o - 16'd1 : o + 16'd1;
      end
      poll;
      rd(8'h01, {2'b00, i[0], !i[0], 8'h00, 4'hf, o});
    end
    fetch(16'd39);
    $display("stepped write test done");
    wr(8'h01, {4'hd, 8'h00, 4'h0, 16'd28});
    for (k = 0; k < 4; k++) begin
      poll;
      if (k == 3) wr(8'h01, {4'h4, 8'h00, 4'h0, 16'd31});
      rd(8'h00, fm[28 + k]);
    end
    rd(8'h01, {4'h4, 8'h00, 4'h0, 16'd31});
    wr(8'h01, {4'he, 8'h00, 4'h0, 16'd40});
    poll;
    rd(8'h00, fm[40]);
    poll;
    wr(8'h01, {4'h4, 8'h00, 4'h0, 16'd39});
    rd(8'h00, fm[39]);
    $display("stepped read test done");
    for (k = 0; k < 16; k += 15) begin
      d = rnd();
      fm[32 + k] = d;
      wr(8'h10 + 8'(k), d);
      fetch(16'd32 + 16'(k));
    end
    wr(8'h01, {4'h3, 8'h00, 4'hf, 16'd5});
    wr(8'h00, rnd());
    poll;
    rd(8'h01, {4'h3, 8'h00, 4'hf, 16'd5});
    fetch(16'd5);
    wr(8'h05, rnd());
    rd(8'h05, 0);
    // Offsets past the fabric must not alias into it and must raise the fault flag
    wr(8'h00, rnd());
    wr(8'h01, {4'h8, 8'h00, 4'hf, 16'h0050});
    wr(8'h01, {4'hc, 12'h000, 16'h0100});
    poll;
    rd(8'h00, 0);
    rd(8'h01, {4'h4, 7'h00, 1'b1, 4'h0, 16'h0100});
    check({31'h0, fault}, 32'h1);
    fetch(16'h0010);
    check({31'h0, fault}, 32'h0);
    $display("direct and odd cases test done");
    repeat (2) @(posedge ref_clk_in);
    finish_test;
  end
endmodule
